// [core/sprs_pkg.sv]
// Constants and types shared by the sensor power and reset sequencer
package sprs_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 125;
    localparam int TMR_W            = 32;
    localparam int RAIL_GAP_US      = 10;
    localparam int RAIL_GAP_CYC     = RAIL_GAP_US * CLK_MHZ;
    localparam int DOWN_GAP_US      = 0;
    // Zero gap is clamped to a count of one, so each step still takes two cycles
    localparam int DOWN_GAP_CYC     = (DOWN_GAP_US * CLK_MHZ < 1) ? 1 : DOWN_GAP_US * CLK_MHZ;
    localparam int RST_HOLD_MS      = 1;
    localparam int RST_HOLD_CYC     = RST_HOLD_MS * 1000 * CLK_MHZ;
    localparam int INIT_REFCLKS     = 850000;
    localparam int PLL_LOCK_MS      = 1;
    localparam int PLL_LOCK_CYC     = PLL_LOCK_MS * 1000 * CLK_MHZ;
    localparam int OFF_MS           = 100;
    localparam int OFF_CYC          = OFF_MS * 1000 * CLK_MHZ;
    localparam int REFCLK_HALF_CYC  = 4;

    // ----------------------------------------------------------------
    // Rails, lowest index powers up first
    // ----------------------------------------------------------------
    localparam int RAIL_N           = 5;
    localparam int RAIL_PLL         = 0;
    localparam int RAIL_ANALOG      = 1;
    localparam int RAIL_IO          = 2;
    localparam int RAIL_CORE        = 3;
    localparam int RAIL_SERIAL      = 4;

    // ----------------------------------------------------------------
    // Control register of the sensor
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_REG_ADDR  = 16'h301a;
    localparam int          STREAM_BIT     = 2;
    localparam logic [15:0] CTRL_BASE_DATA = 16'h0000;

    typedef enum logic [3:0] {
        S_OFF_WAIT,
        S_IDLE,
        S_RAIL_UP,
        S_RESET,
        S_INIT,
        S_CONFIG,
        S_LOCK,
        S_READY,
        S_WR_ON,
        S_STREAM,
        S_WR_OFF,
        S_DRAIN,
        S_RAIL_DOWN
    } sprs_state_type;

endpackage : sprs_pkg

// [core/sprs_timer.sv]
// Down-counting wait timer with a load pulse and a tick enable
`timescale 1ns/1ps
`default_nettype none
module sprs_timer
    import sprs_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             start_i,
    input  wire logic [TMR_W-1:0] count_i,
    input  wire logic             tick_i,
    output logic                  done_o
);
    logic [TMR_W-1:0] remain;
    logic             armed;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            remain <= '0;
            armed  <= 1'b0;
        end
        else if (start_i)
        begin
            remain <= count_i;
            armed  <= 1'b1;
        end
        else if (tick_i && remain != '0)
        begin
            remain <= remain - 1'b1;
        end
    end

    // Done holds until the next load; it ignores the load, which is built from it
    assign done_o = armed && (remain == '0);
endmodule : sprs_timer
`default_nettype wire

// [core/sprs_clkdiv.sv]
// Divider giving a one-cycle enable at each reference clock half period
`timescale 1ns/1ps
`default_nettype none
module sprs_clkdiv
    import sprs_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic run_i,
    output logic      tick_o
);
    logic [7:0] cnt;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt <= 8'h00;
        else if (!run_i || cnt == 8'(REFCLK_HALF_CYC - 1))
            cnt <= 8'h00;
        else
            cnt <= cnt + 8'h01;
    end

    assign tick_o = run_i && (cnt == 8'(REFCLK_HALF_CYC - 1));
endmodule : sprs_clkdiv
`default_nettype wire

// [core/sprs_host.sv]
// Host-side power, reset and streaming sequencer for the image sensor
// --------------------------------------------------------------------
// --------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sprs_host
    import sprs_pkg::*;
#(
    parameter int RST_HOLD  = RST_HOLD_CYC,
    parameter int INIT_CLKS = INIT_REFCLKS,
    parameter int PLL_LOCK  = PLL_LOCK_CYC,
    parameter int OFF_TIME  = OFF_CYC
)
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        power_up_i,
    input  wire logic        power_down_i,
    input  wire logic        abrupt_off_i,
    input  wire logic        cfg_done_i,
    input  wire logic        stream_req_i,
    input  wire logic        reg_wr_ack_i,
    input  wire logic        stream_idle_i,
    output logic             pll_rail_en_o,
    output logic             analog_supply_rail_en_o,
    output logic             io_rail_en_o,
    output logic             core_rail_en_o,
    output logic             serial_output_supply_rail_en_o,
    output logic             reference_clock_input_o,
    output logic             sensor_resetn_o,
    output logic             cfg_allowed_o,
    output logic             reg_wr_req_o,
    output logic [15:0]      reg_wr_addr_o,
    output logic [15:0]      reg_wr_data_o,
    output logic             ready_o,
    output logic             streaming_o,
    output logic             powered_off_o
);
    // ----------------------------------------------------------------
    // State and helpers
    // ----------------------------------------------------------------
    sprs_state_type    state;
    sprs_state_type    next_state;
    logic [2:0]        rail_lvl;
    logic [RAIL_N-1:0] rail_en;
    logic              ref_clk;
    logic              ref_run;
    logic              div_tick;
    logic              ref_rise;
    logic              tmr_start;
    logic              tmr_done;
    logic              tmr_tick;
    logic [TMR_W-1:0]  tmr_count;
    logic              rail_step;
    logic              powered;
    logic              boot;

    assign ref_rise  = div_tick && !ref_clk;
    assign powered   = (state != S_OFF_WAIT) && (state != S_IDLE);
    assign rail_step = tmr_done && ((state == S_RAIL_UP && rail_lvl != 3'(RAIL_N))
                                 || (state == S_RAIL_DOWN && rail_lvl != 3'h0));
    assign tmr_start = boot || (next_state != state) || rail_step;
    // init in reference clocks
    // Initialization is counted in reference clocks, the rest in system cycles
    assign tmr_tick  = (state == S_INIT) ? ref_rise : 1'b1;

    sprs_timer u_timer (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .start_i  (tmr_start),
        .count_i  (tmr_count),
        .tick_i   (tmr_tick),
        .done_o   (tmr_done)
    );

    sprs_clkdiv u_clkdiv (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .run_i    (ref_run),
        .tick_o   (div_tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (abrupt_off_i && powered)
        begin
            next_state = S_OFF_WAIT;
        end
        else
        begin
            unique case (state)
                S_OFF_WAIT:
                    if (tmr_done)
                        next_state = S_IDLE;
                S_IDLE:
                    if (power_up_i)
                        next_state = S_RAIL_UP;
                S_RAIL_UP:
                    if (tmr_done && rail_lvl == 3'(RAIL_N))
                        next_state = S_RESET;
                S_RESET:
                    if (power_down_i)
                        next_state = S_RAIL_DOWN;
                    else if (tmr_done)
                        next_state = S_INIT;
                S_INIT:
                    if (power_down_i)
                        next_state = S_RAIL_DOWN;
                    else if (tmr_done)
                        next_state = S_CONFIG;
                S_CONFIG:
                    if (power_down_i)
                        next_state = S_RAIL_DOWN;
                    else if (cfg_done_i)
                        next_state = S_LOCK;
                S_LOCK:
                    if (power_down_i)
                        next_state = S_RAIL_DOWN;
                    else if (tmr_done)
                        next_state = S_READY;
                S_READY:
                    if (power_down_i)
                        next_state = S_RAIL_DOWN;
                    else if (stream_req_i)
                        next_state = S_WR_ON;
                S_WR_ON:
                    if (reg_wr_ack_i)
                        next_state = S_STREAM;
                S_STREAM:
                    if (power_down_i || !stream_req_i)
                        next_state = S_WR_OFF;
                S_WR_OFF:
                    if (reg_wr_ack_i)
                        next_state = S_DRAIN;
                S_DRAIN:
                    if (stream_idle_i)
                        next_state = S_READY;
                S_RAIL_DOWN:
                    if (tmr_done && rail_lvl == 3'h0)
                        next_state = S_OFF_WAIT;
                default:
                    next_state = S_OFF_WAIT;
            endcase
        end
    end

    always_comb
    begin
        unique case (next_state)
            S_OFF_WAIT:  tmr_count = TMR_W'(OFF_TIME);
            S_RAIL_UP:   tmr_count = TMR_W'(RAIL_GAP_CYC);
            S_RESET:     tmr_count = TMR_W'(RST_HOLD);
            S_INIT:      tmr_count = TMR_W'(INIT_CLKS);
            S_LOCK:      tmr_count = TMR_W'(PLL_LOCK);
            S_RAIL_DOWN: tmr_count = TMR_W'(DOWN_GAP_CYC);
            default:     tmr_count = TMR_W'(1);
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state <= S_OFF_WAIT;
        else
            state <= next_state;
    end

    // No state change follows reset, so this loads the off-time wait
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            boot <= 1'b1;
        else
            boot <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Rails
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rail_lvl <= 3'h0;
        else if (next_state == S_OFF_WAIT)
            rail_lvl <= 3'h0;
        else if (rail_step && state == S_RAIL_UP)
            rail_lvl <= rail_lvl + 3'h1;
        else if (rail_step)
            rail_lvl <= rail_lvl - 3'h1;
    end

    // Thermometer enables: a rail is on only with every lower rail on
    genvar gi;
    generate
        for (gi = 0; gi < RAIL_N; gi++)
        begin : g_rail
            always_ff @(posedge clock_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    rail_en[gi] <= 1'b0;
                else
                    rail_en[gi] <= (next_state != S_OFF_WAIT)
                        && ((rail_step && state == S_RAIL_UP) ? (rail_lvl >= 3'(gi))
                        : (rail_step ? (rail_lvl > 3'(gi + 1)) : (rail_lvl > 3'(gi))));
            end
        end
    endgenerate

    assign pll_rail_en_o                  = rail_en[RAIL_PLL];
    assign analog_supply_rail_en_o        = rail_en[RAIL_ANALOG];
    assign io_rail_en_o                   = rail_en[RAIL_IO];
    assign core_rail_en_o                 = rail_en[RAIL_CORE];
    assign serial_output_supply_rail_en_o = rail_en[RAIL_SERIAL];

    // ----------------------------------------------------------------
    // Reference clock and sensor reset
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ref_run <= 1'b0;
        else
            ref_run <= (next_state inside {S_RESET, S_INIT, S_CONFIG, S_LOCK,
                        S_READY, S_WR_ON, S_STREAM, S_WR_OFF, S_DRAIN});
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ref_clk <= 1'b0;
        // A cut stops the clock together with the rails
        else if (!ref_run || next_state == S_OFF_WAIT)
            ref_clk <= 1'b0;
        else if (div_tick)
            ref_clk <= !ref_clk;
    end

    assign reference_clock_input_o = ref_clk;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sensor_resetn_o <= 1'b0;
        else
            sensor_resetn_o <= ref_run && (next_state != S_RESET)
                && (next_state != S_RAIL_DOWN) && (next_state != S_OFF_WAIT);
    end

    // ----------------------------------------------------------------
    // Register writes and status
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cfg_allowed_o <= 1'b0;
        else
            cfg_allowed_o <= (next_state == S_CONFIG);
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reg_wr_req_o  <= 1'b0;
            reg_wr_addr_o <= 16'h0000;
            reg_wr_data_o <= 16'h0000;
        end
        else
        begin
            reg_wr_req_o  <= (next_state == S_WR_ON) || (next_state == S_WR_OFF);
            reg_wr_addr_o <= CTRL_REG_ADDR;
            reg_wr_data_o <= CTRL_BASE_DATA;
            reg_wr_data_o[STREAM_BIT] <= (next_state == S_WR_ON);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ready_o       <= 1'b0;
            streaming_o   <= 1'b0;
            powered_off_o <= 1'b1;
        end
        else
        begin
            ready_o       <= (next_state == S_READY);
            streaming_o   <= (next_state == S_STREAM);
            powered_off_o <= (next_state == S_OFF_WAIT) || (next_state == S_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [TMR_W-1:0] hold_cnt;
    logic [TMR_W-1:0] init_cnt;
    logic [TMR_W-1:0] lock_cnt;
    logic [TMR_W-1:0] off_cnt;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hold_cnt <= '0;
            init_cnt <= '0;
            lock_cnt <= '0;
            off_cnt  <= '0;
        end
        else
        begin
            hold_cnt <= !ref_run ? '0 : hold_cnt + TMR_W'(hold_cnt != '1);
            init_cnt <= !sensor_resetn_o ? '0 : init_cnt + TMR_W'(ref_rise);
            lock_cnt <= (state == S_CONFIG) ? '0 : lock_cnt + TMR_W'(lock_cnt != '1);
            off_cnt  <= (rail_en != '0) ? '0 : off_cnt + TMR_W'(off_cnt != '1);
        end
    end

    AST_PLL_FIRST: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (rail_en[RAIL_N-1:1] != '0) |-> rail_en[RAIL_PLL])
        else $error("rail on without PLL rail");
    AST_RAIL_ORDER: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (((rail_en + 5'h01) & rail_en) == 5'h00)
        && !($rose(rail_en[RAIL_ANALOG]) && $rose(rail_en[RAIL_PLL])))
        else $error("rails out of order");
    AST_CLK_AFTER_RAILS: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(ref_clk) |-> (&rail_en))
        else $error("reference clock before rails");
    AST_RESET_HOLD: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(sensor_resetn_o) |-> (hold_cnt >= TMR_W'(RST_HOLD)))
        else $error("sensor reset released early");
    AST_INIT_WAIT: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(cfg_allowed_o) |-> (init_cnt >= TMR_W'(INIT_CLKS)) && sensor_resetn_o)
        else $error("configuration before initialization");
    AST_LOCK_WAIT: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(reg_wr_req_o) && reg_wr_data_o[STREAM_BIT]
        |-> (lock_cnt >= TMR_W'(PLL_LOCK)))
        else $error("streaming before PLL lock");
    AST_STREAM_WRITE: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state == S_WR_ON) && reg_wr_ack_i
        |=> streaming_o && (reg_wr_addr_o == CTRL_REG_ADDR) && !reg_wr_req_o)
        else $error("stream on write malformed");
    AST_DOWN_ORDER: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $fell(rail_en[RAIL_SERIAL]) && !$past(abrupt_off_i)
        |-> !streaming_o && !sensor_resetn_o && rail_en[RAIL_CORE] ##2 !rail_en[RAIL_CORE])
        else $error("ordered power-down broken");
    AST_ABRUPT: assert property (@(posedge clock_i) disable iff (!resetn_i)
        abrupt_off_i && rail_en[RAIL_PLL] |=> (rail_en == '0) && powered_off_o)
        else $error("abrupt cut left a rail on");
    AST_OFF_TIME: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(rail_en[RAIL_PLL]) |-> (off_cnt >= TMR_W'(OFF_TIME)))
        else $error("power-up too soon after power-down");
endmodule : sprs_host
`default_nettype wire

// [dv/sprs_sensor_model.sv]
// Behavioural image sensor facing the power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module sprs_sensor_model
    import sprs_pkg::*;
#(
    parameter int RST_HOLD  = 20,
    parameter int INIT_CLKS = 10,
    parameter int PLL_LOCK  = 20,
    parameter int OFF_TIME  = 50,
    parameter int ROW_CYC   = 6
)
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [4:0]  rails_i,
    input  wire logic        refclk_i,
    input  wire logic        sensor_resetn_i,
    input  wire logic        cfg_allowed_i,
    input  wire logic        wr_req_i,
    input  wire logic [15:0] wr_addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic [3:0]  ack_dly_i,
    output logic             wr_ack_o,
    output logic             idle_o,
    output logic             stream_o,
    output logic             init_done_o,
    output logic [7:0]       viol_o
);
    int         hold_n;
    int         init_n;
    int         lock_n;
    int         off_n;
    int         row_n;
    logic [3:0] ack_n;
    logic       refclk_q;
    logic       rstn_q;
    logic       pll_q;
    logic       cfg_seen;
    logic [7:0] bad;

    assign init_done_o = (init_n >= INIT_CLKS);
    assign idle_o      = !stream_o && (row_n == 0);

    // ----------------------------------------------------------------
    // Misuse by the host, one sticky flag each
    // ----------------------------------------------------------------
    always_comb
    begin
        bad    = 8'h00;
        bad[0] = |(rails_i[4:1] & ~rails_i[3:0]);
        bad[1] = refclk_i && !rails_i[4];
        bad[2] = sensor_resetn_i && !rstn_q && (hold_n < RST_HOLD);
        bad[3] = cfg_allowed_i && !init_done_o;
        // Stream only after config and lock
        bad[4] = wr_req_i && wr_data_i[STREAM_BIT] && (!cfg_seen || lock_n < PLL_LOCK);
        bad[5] = rails_i[0] && !pll_q && (off_n < OFF_TIME);
        // Only the control register is modelled
        bad[6] = wr_req_i && (wr_addr_i != CTRL_REG_ADDR);
        bad[7] = wr_req_i && !init_done_o;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            {hold_n, init_n, lock_n, off_n, row_n} <= '0;
            {ack_n, refclk_q, rstn_q, pll_q, cfg_seen} <= '0;
            {wr_ack_o, stream_o, viol_o} <= '0;
        end
        else
        begin
            refclk_q <= refclk_i;
            rstn_q   <= sensor_resetn_i;
            pll_q    <= rails_i[0];
            hold_n   <= (&rails_i && !sensor_resetn_i) ? hold_n + 1 : 0;
            off_n    <= (rails_i == 5'h00) ? off_n + 1 : 0;
            cfg_seen <= sensor_resetn_i && (cfg_seen || cfg_allowed_i);
            lock_n   <= (cfg_seen && !cfg_allowed_i) ? lock_n + 1 : 0;
            viol_o   <= viol_o | bad;
            wr_ack_o <= 1'b0;
            if (!sensor_resetn_i)
                init_n <= 0;
            else if (refclk_i && !refclk_q && !init_done_o)
                init_n <= init_n + 1;
            // Ack delay set by the bench, prompt or slow
            if (wr_req_i && !wr_ack_o)
            begin
                ack_n <= ack_n + 4'h1;
                if (ack_n >= ack_dly_i)
                begin
                    ack_n    <= 4'h0;
                    wr_ack_o <= 1'b1;
                    stream_o <= wr_data_i[STREAM_BIT];
                end
            end
            // Finish the row before soft standby
            if (stream_o)
                row_n <= ROW_CYC;
            else if (row_n != 0)
                row_n <= row_n - 1;
            // Sudden loss of all rails is harmless
            if (!rails_i[0])
            begin
                stream_o <= 1'b0;
                row_n    <= 0;
            end
        end
    end
endmodule : sprs_sensor_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the sensor power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sprs_pkg::*;
;
    localparam int RST_HOLD  = 20;
    localparam int INIT_CLKS = 10;
    localparam int PLL_LOCK  = 20;
    localparam int OFF_TIME  = 50;
    localparam int ROW_CYC   = 6;

    logic        clock_i;
    logic        resetn_i;
    logic        power_up_i;
    logic        power_down_i;
    logic        abrupt_off_i;
    logic        cfg_done_i;
    logic        stream_req_i;
    logic [3:0]  ack_dly;
    wire  [4:0]  rails;
    wire         refclk, sresetn, cfg_allowed, wr_req, ready, streaming, powered_off;
    wire         wr_ack, idle, m_stream, m_init;
    wire  [15:0] wr_addr, wr_data;
    wire  [7:0]  viol;
    int          n_fail;
    int          samples_checked;

    sprs_host #(.RST_HOLD(RST_HOLD), .INIT_CLKS(INIT_CLKS), .PLL_LOCK(PLL_LOCK),
                .OFF_TIME(OFF_TIME)) dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .power_up_i(power_up_i),
        .power_down_i(power_down_i), .abrupt_off_i(abrupt_off_i), .cfg_done_i(cfg_done_i),
        .stream_req_i(stream_req_i), .reg_wr_ack_i(wr_ack), .stream_idle_i(idle),
        .pll_rail_en_o(rails[0]), .analog_supply_rail_en_o(rails[1]), .io_rail_en_o(rails[2]),
        .core_rail_en_o(rails[3]), .serial_output_supply_rail_en_o(rails[4]),
        .reference_clock_input_o(refclk), .sensor_resetn_o(sresetn),
        .cfg_allowed_o(cfg_allowed), .reg_wr_req_o(wr_req), .reg_wr_addr_o(wr_addr),
        .reg_wr_data_o(wr_data), .ready_o(ready), .streaming_o(streaming),
        .powered_off_o(powered_off));

    sprs_sensor_model #(.RST_HOLD(RST_HOLD), .INIT_CLKS(INIT_CLKS), .PLL_LOCK(PLL_LOCK),
                        .OFF_TIME(OFF_TIME), .ROW_CYC(ROW_CYC)) model (
        .clock_i(clock_i), .resetn_i(resetn_i), .rails_i(rails), .refclk_i(refclk),
        .sensor_resetn_i(sresetn), .cfg_allowed_i(cfg_allowed), .wr_req_i(wr_req),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .ack_dly_i(ack_dly), .wr_ack_o(wr_ack),
        .idle_o(idle), .stream_o(m_stream), .init_done_o(m_init), .viol_o(viol));

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic probe(input int k);
        if (k < 5)
            return rails[k];
        case (k)
            5:       return sresetn;
            6:       return cfg_allowed;
            7:       return ready;
            8:       return streaming;
            default: return powered_off;
        endcase
    endfunction : probe

    // Bounded wait on one status line
    task automatic wait_hi(input int k, input int lim, output int n);
        n = 0;
        while (probe(k) !== 1'b1 && n < lim)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= lim)
            chk("wait limit", 16'(k), 16'hffff);
    endtask : wait_hi

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_powerup;
        int   n;
        int   c;
        logic p;
        power_up_i = 1'b1;
        wait_hi(0, 3000, n);
        power_up_i = 1'b0;
        for (int k = 1; k < 5; k++)
        begin
            wait_hi(k, 3000, n);
            chk("rail gap", 16'(n >= RAIL_GAP_CYC && n <= RAIL_GAP_CYC + 2), 16'h0001);
        end
        chk("refclk idle", 16'(refclk), 16'h0000);
        wait_hi(5, 3000, n);
        chk("reset hold", 16'(n >= RAIL_GAP_CYC + RST_HOLD), 16'h0001);
        c = 0;
        p = refclk;
        while (cfg_allowed !== 1'b1 && c < 1000)
        begin
            @(negedge clock_i);
            if (refclk && !p)
                c++;
            p = refclk;
        end
        // Rises during the reset hold are not part of the count
        chk("init clocks", 16'(c), 16'(INIT_CLKS));
        chk("device init", 16'(m_init), 16'h0001);
    endtask : t_powerup

    task automatic t_config;
        int n;
        cfg_done_i = 1'b1;
        @(negedge clock_i);
        cfg_done_i = 1'b0;
        @(negedge clock_i);
        chk("cfg window", 16'(cfg_allowed), 16'h0000);
        wait_hi(7, 500, n);
        chk("pll lock", 16'(n >= PLL_LOCK), 16'h0001);
    endtask : t_config

    task automatic t_stream(input logic [3:0] dly);
        int n;
        ack_dly      = dly;
        stream_req_i = 1'b1;
        @(negedge clock_i);
        chk("on req", 16'(wr_req), 16'h0001);
        chk("on data", wr_data, CTRL_BASE_DATA | (16'h0001 << STREAM_BIT));
        wait_hi(8, 100, n);
        chk("stream on", 16'(m_stream), 16'h0001);
        chk("ctrl addr", wr_addr, CTRL_REG_ADDR);
        chk("ready busy", 16'(ready), 16'h0000);
        stream_req_i = 1'b0;
        @(negedge clock_i);
        chk("off req", 16'(wr_req), 16'h0001);
        chk("off data", wr_data, CTRL_BASE_DATA);
        wait_hi(7, 200, n);
        chk("drain time", 16'(n >= ROW_CYC), 16'h0001);
        chk("standby", 16'({m_stream, idle}), 16'h0001);
        chk("stream off", 16'(streaming), 16'h0000);
    endtask : t_stream

    task automatic t_down;
        int n;
        stream_req_i = 1'b1;
        wait_hi(8, 100, n);
        power_down_i = 1'b1;
        wait_hi(9, 500, n);
        power_down_i = 1'b0;
        stream_req_i = 1'b0;
        chk("rails off", 16'(rails), 16'h0000);
        chk("stop first", 16'(m_stream), 16'h0000);
    endtask : t_down

    task automatic t_abrupt;
        abrupt_off_i = 1'b1;
        @(negedge clock_i);
        abrupt_off_i = 1'b0;
        @(negedge clock_i);
        chk("cut all", 16'({rails, refclk, sresetn}), 16'h0000);
        chk("off state", 16'(powered_off), 16'h0001);
    endtask : t_abrupt

    initial
    begin
        {resetn_i, power_up_i, power_down_i, abrupt_off_i, cfg_done_i, stream_req_i} = '0;
        ack_dly         = 4'h0;
        n_fail          = 0;
        samples_checked = 0;
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        chk("reset off", 16'({powered_off, rails}), 16'h0020);
        t_powerup();
        t_config();
        t_stream(4'h0);
        t_stream(4'h5);
        t_down();
        t_powerup();
        t_abrupt();
        t_powerup();
        chk("device flags", 16'(viol), 16'h0000);
        give_verdict();
    end

    // Three power-ups of about 7600 cycles each, with margin
    initial
    begin
        #(8 * 60000);
        n_fail++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
